// *** iosg_pkg.sv ***
package iosg_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_PINS = 4;

    // Register offsets
    localparam logic [7:0] OFS_IO_VOLTAGE_CONTROL = 8'h0d;
    localparam logic [7:0] OFS_PIN_LEVEL_READBACK = 8'h0e;
    localparam logic [7:0] OFS_PIN_INPUT_GATING   = 8'h0f;

    // io_voltage_control fields
    localparam int BIT_HIGH_VOLTAGE_SELECT = 7;
    localparam int BIT_SUPPLY_OVERRIDE     = 6;
    localparam int LSB_SUPPLY_LEVEL        = 4;
    localparam int LSB_IOV_RESERVED        = 0;

    // pin_level_readback fields
    localparam int LSB_PIN_STATUS          = 0;
    localparam int LSB_PLR_RESERVED        = 4;

    // pin_input_gating fields
    localparam int LSB_PIG_RESERVED        = 4;
    localparam int LSB_INPUT_ENABLE        = 0;

    // Supply level encodings
    localparam logic [1:0] SUPPLY_LEVEL_1V8 = 2'h0;
    localparam logic [1:0] SUPPLY_LEVEL_3V3 = 2'h3;

    // Reset values
    localparam logic       RST_HIGH_VOLTAGE_SELECT = 1'h0;
    localparam logic       RST_SUPPLY_OVERRIDE     = 1'h0;
    localparam logic [1:0] RST_SUPPLY_LEVEL        = 2'h0;
    localparam logic [3:0] RST_IOV_RESERVED        = 4'h9;
    localparam logic [3:0] RST_PLR_RESERVED        = 4'h0;
    localparam logic [3:0] RST_PIG_RESERVED        = 4'h7;
    localparam logic [3:0] RST_INPUT_ENABLE        = 4'hf;
    localparam logic [7:0] RST_READ_DATA           = 8'h00;

endpackage

// *** iosg_pin_sync.sv ***
`timescale 1ns/10ps
// Three-stage synchroniser; a change is taken once stages 2 and 3 agree
module iosg_pin_sync
    import iosg_pkg::*;
#(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    // Asynchronous input and filtered result
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_level
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] next_level;

    always_comb begin
        next_level = level;
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
                next_level[i] = stage3[i];
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level  <= '0;
        end else begin
            stage1 <= i_async;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end

    assign o_level = level;

endmodule

// *** iosg_regs.sv ***
`timescale 1ns/10ps
// Overview of operation
// - Bit 7 picks I/O level for interrupt and bus pins; 0=1.8V, 1=3.3V.
// - Override bit 6 low: detected supply level drives both controls.
// - Override bit 6 high: software-written select and level fields apply.
// - Override low: reads of select and level fields return detected level.
// - Supply level field bits 5:4: 00 is 1.8V, 11 is 3.3V; resets zero.
// - Read-only bits 3:0 show present levels of the four pins.
// - Per-pin input enable bits 3:0, one enables, all reset enabled.
module iosg_regs
    import iosg_pkg::*;
#(
    parameter int PINS = NUM_PINS
) (
    // Clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    // Register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [DATA_W-1:0] o_rdata,
    // Supply detection, 1 when 3.3V rail detected
    input  wire logic              i_io_supply_rail_3v3,
    // General-purpose pins
    input  wire logic [PINS-1:0]   i_pin,
    output logic      [PINS-1:0]   o_pin_gated,
    // Applied I/O level controls
    output logic                   o_io_high_voltage_select,
    output logic      [1:0]        o_supply_level
);

    logic              sel_wr;
    logic              override;
    logic [1:0]        level_wr;
    logic [3:0]        iov_rsvd;
    logic [3:0]        plr_rsvd;
    logic [3:0]        pig_rsvd;
    logic [PINS-1:0]   input_enable;
    logic [DATA_W-1:0] rdata;
    logic              applied_sel;
    logic [1:0]        applied_level;
    logic [PINS-1:0]   pin_gated;

    logic              next_sel_wr;
    logic              next_override;
    logic [1:0]        next_level_wr;
    logic [3:0]        next_iov_rsvd;
    logic [3:0]        next_plr_rsvd;
    logic [3:0]        next_pig_rsvd;
    logic [PINS-1:0]   next_input_enable;
    logic [DATA_W-1:0] next_rdata;
    logic              next_applied_sel;
    logic [1:0]        next_applied_level;
    logic [PINS-1:0]   next_pin_gated;

    logic [PINS-1:0]   pin_level;
    logic              rail_3v3;
    logic              det_sel;
    logic [1:0]        det_level;

    iosg_pin_sync #(
        .WIDTH (PINS + 1)
    ) u_sync (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_async ({i_io_supply_rail_3v3, i_pin}),
        .o_level ({rail_3v3, pin_level})
    );

    // Detected rail mapped onto both controls
    assign det_sel   = rail_3v3;
    assign det_level = rail_3v3 ? SUPPLY_LEVEL_3V3 : SUPPLY_LEVEL_1V8;

    // Register select positions within a decoded one-hot word
    localparam int HIT_IOV = 0;
    localparam int HIT_PLR = 1;
    localparam int HIT_PIG = 2;
    localparam int HIT_W   = 3;

    logic [HIT_W-1:0] wr_hit;
    logic [HIT_W-1:0] rd_hit;
    logic [2:0]       written_ctl;
    logic [2:0]       detected_ctl;
    logic [2:0]       effective_ctl;

    // One-hot register select, shared by the write and read paths
    function automatic logic [HIT_W-1:0] reg_select(
        input logic [ADDR_W-1:0] addr
    );
        logic [HIT_W-1:0] hit;
        hit          = '0;
        hit[HIT_IOV] = (addr == OFS_IO_VOLTAGE_CONTROL);
        hit[HIT_PLR] = (addr == OFS_PIN_LEVEL_READBACK);
        hit[HIT_PIG] = (addr == OFS_PIN_INPUT_GATING);
        return hit;
    endfunction

    // Select and level as one word: software copy or detected rail
    function automatic logic [2:0] pick_ctl(
        input logic       use_written,
        input logic [2:0] written,
        input logic [2:0] detected
    );
        return use_written ? written : detected;
    endfunction

    // Unmapped addresses decode to no register: writes are dropped
    assign wr_hit = i_wr ? reg_select(i_addr) : '0;
    assign rd_hit = i_rd ? reg_select(i_addr) : '0;

    // Pins and software readback see the same effective word
    assign written_ctl   = {sel_wr, level_wr};
    assign detected_ctl  = {det_sel, det_level};
    assign effective_ctl = pick_ctl(override, written_ctl,
                                    detected_ctl);

    // io_voltage_control: software copy of select, override, level, spare
    always_comb begin
        next_sel_wr   = sel_wr;
        next_override = override;
        next_level_wr = level_wr;
        next_iov_rsvd = iov_rsvd;
        if (wr_hit[HIT_IOV]) begin
            next_sel_wr   = i_wdata[BIT_HIGH_VOLTAGE_SELECT];
            next_override = i_wdata[BIT_SUPPLY_OVERRIDE];
            next_level_wr = i_wdata[LSB_SUPPLY_LEVEL +: 2];
            next_iov_rsvd = i_wdata[LSB_IOV_RESERVED +: 4];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sel_wr   <= RST_HIGH_VOLTAGE_SELECT;
            override <= RST_SUPPLY_OVERRIDE;
            level_wr <= RST_SUPPLY_LEVEL;
            iov_rsvd <= RST_IOV_RESERVED;
        end else begin
            sel_wr   <= next_sel_wr;
            override <= next_override;
            level_wr <= next_level_wr;
            iov_rsvd <= next_iov_rsvd;
        end
    end

    // pin_level_readback: only the spare upper half is writable
    always_comb begin
        next_plr_rsvd = plr_rsvd;
        if (wr_hit[HIT_PLR]) begin
            next_plr_rsvd = i_wdata[LSB_PLR_RESERVED +: 4];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            plr_rsvd <= RST_PLR_RESERVED;
        end else begin
            plr_rsvd <= next_plr_rsvd;
        end
    end

    // pin_input_gating: spare half and one enable per pin
    always_comb begin
        next_pig_rsvd     = pig_rsvd;
        next_input_enable = input_enable;
        if (wr_hit[HIT_PIG]) begin
            next_pig_rsvd     = i_wdata[LSB_PIG_RESERVED +: 4];
            next_input_enable = i_wdata[LSB_INPUT_ENABLE +: PINS];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pig_rsvd     <= RST_PIG_RESERVED;
            input_enable <= RST_INPUT_ENABLE;
        end else begin
            pig_rsvd     <= next_pig_rsvd;
            input_enable <= next_input_enable;
        end
    end

    // Applied controls, registered so the pad drivers see clean levels
    always_comb begin
        next_applied_sel   = effective_ctl[2];
        next_applied_level = effective_ctl[1:0];
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            applied_sel   <= RST_HIGH_VOLTAGE_SELECT;
            applied_level <= RST_SUPPLY_LEVEL;
        end else begin
            applied_sel   <= next_applied_sel;
            applied_level <= next_applied_level;
        end
    end

    // Per-pin input gate; a disabled pin shows low on the gated bus
    for (genvar p = 0; p < PINS; p++) begin : g_gate
        assign next_pin_gated[p] = pin_level[p] & input_enable[p];
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pin_gated <= '0;
        end else begin
            pin_gated <= next_pin_gated;
        end
    end

    // Read data, valid the cycle after the strobe and zero otherwise
    always_comb begin
        next_rdata = '0;
        if (rd_hit[HIT_IOV]) begin
            next_rdata[BIT_HIGH_VOLTAGE_SELECT] = effective_ctl[2];
            next_rdata[BIT_SUPPLY_OVERRIDE]     = override;
            next_rdata[LSB_SUPPLY_LEVEL +: 2]   = effective_ctl[1:0];
            next_rdata[LSB_IOV_RESERVED +: 4]   = iov_rsvd;
        end else if (rd_hit[HIT_PLR]) begin
            next_rdata[LSB_PLR_RESERVED +: 4]  = plr_rsvd;
            next_rdata[LSB_PIN_STATUS +: PINS] = pin_level;
        end else if (rd_hit[HIT_PIG]) begin
            next_rdata[LSB_PIG_RESERVED +: 4]    = pig_rsvd;
            next_rdata[LSB_INPUT_ENABLE +: PINS] = input_enable;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rdata <= RST_READ_DATA;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign o_rdata                  = rdata;
    assign o_io_high_voltage_select = applied_sel;
    assign o_supply_level           = applied_level;
    assign o_pin_gated              = pin_gated;

endmodule

// *** iosg_regs_chk.sv ***
`timescale 1ns/10ps
module iosg_regs_chk
    import iosg_pkg::*;
#(parameter int PINS = NUM_PINS) (
    // Clock, reset and register port
    input wire logic            i_mclk,
    input wire logic            i_rst,
    input wire logic [7:0]      i_addr,
    input wire logic [7:0]      i_wdata,
    input wire logic            i_wr,
    input wire logic            i_rd,
    input wire logic [7:0]      o_rdata,
    // Supply and pins
    input wire logic            i_io_supply_rail_3v3,
    input wire logic [PINS-1:0] i_pin,
    input wire logic [PINS-1:0] o_pin_gated,
    input wire logic            o_io_high_voltage_select,
    input wire logic [1:0]      o_supply_level
);
    logic [7:0]    iov;
    logic [7:0]    pig;
    logic [3:0]    q;
    logic [PINS:0] prev;
    logic          wr_d;
    logic          rd_d;
    logic [2:0]    lvl;
    assign wr_d = i_wr && i_addr == OFS_IO_VOLTAGE_CONTROL;
    assign rd_d = i_rd && i_addr == OFS_IO_VOLTAGE_CONTROL;
    assign lvl = {o_io_high_voltage_select, o_supply_level};
    // Mirrors of written values; q counts quiet cycles since a write or
    // input change, so synchroniser latency is out of the way
    always_ff @(posedge i_mclk) begin
        prev <= {i_io_supply_rail_3v3, i_pin};
        iov <= i_rst ? 8'h09 : wr_d ? i_wdata : iov;
        pig <= i_rst ? 8'h7f
            : (i_wr && i_addr == OFS_PIN_INPUT_GATING) ? i_wdata : pig;
        q <= (i_rst || i_wr || prev != {i_io_supply_rail_3v3, i_pin})
            ? 4'h0 : q + 4'(q != 4'hf);
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    sequence s_ovr_wr;
        wr_d && i_wdata[6] ##1 !wr_d;
    endsequence
    AST_RST: assert property (disable iff (1'b0) i_rst |=>
        o_rdata == 8'h00 && lvl == 3'h0 && o_pin_gated == '0)
        else $error("Outputs not cleared by reset");
    AST_RD_IDLE: assert property ((!i_rd || i_addr < 8'h0d
        || i_addr > 8'h0f) |=> o_rdata == 8'h00) else $error("Stray read data");
    AST_RD_GATE: assert property (i_rd && i_addr == 8'h0f |=>
        o_rdata == $past(pig)) else $error("Input gating readback wrong");
    AST_RD_OVR: assert property (rd_d && iov[6] |=>
        o_rdata == $past(iov)) else $error("Override readback wrong");
    AST_RD_DET: assert property (rd_d && !iov[6] && q >= 4'h8 |=>
        {o_rdata[7], o_rdata[5:4]} == {3{$past(i_io_supply_rail_3v3)}})
        else $error("Detected level not read back");
    AST_RD_PIN: assert property (i_rd && i_addr == 8'h0e && q >= 4'h8 |=>
        o_rdata[3:0] == $past(i_pin)) else $error("Pin status wrong");
    AST_DET: assert property (!iov[6] && q >= 4'h8 |->
        lvl == {3{i_io_supply_rail_3v3}}) else $error("Detected level unused");
    AST_WR_OVR: assert property (s_ovr_wr |=>
        lvl == {iov[7], iov[5:4]}) else $error("Written level not applied");
    AST_GATED: assert property (q >= 4'h8 |->
        o_pin_gated == (i_pin & pig[3:0])) else $error("Pin gating wrong");
endmodule
bind iosg_regs iosg_regs_chk #(.PINS(PINS)) i_chk (
    .i_mclk                   (i_mclk),
    .i_rst                    (i_rst),
    .i_addr                   (i_addr),
    .i_wdata                  (i_wdata),
    .i_wr                     (i_wr),
    .i_rd                     (i_rd),
    .o_rdata                  (o_rdata),
    .i_io_supply_rail_3v3     (i_io_supply_rail_3v3),
    .i_pin                    (i_pin),
    .o_pin_gated              (o_pin_gated),
    .o_io_high_voltage_select (o_io_high_voltage_select),
    .o_supply_level           (o_supply_level)
);

// *** iosg_regs_tb.sv ***
`timescale 1ns/10ps
module iosg_regs_tb
    import iosg_pkg::*;
;
    localparam logic [7:0] CORNER [4] = '{8'h40, 8'hf0, 8'h3f, 8'hb6};
    logic       i_mclk = 1'b0;
    logic       i_rst = 1'b1;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    logic       i_io_supply_rail_3v3 = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic [3:0] i_pin = 4'h5;
    logic [7:0] o_rdata;
    logic [3:0] o_pin_gated;
    logic       o_io_high_voltage_select;
    logic [1:0] o_supply_level;
    logic [7:0] d;
    logic [7:0] g;
    logic [7:0] e;
    logic [7:0] v;
    logic [7:0] ua;
    int         errors = 0;
    int         comparisons = 0;
    int         seed = 32'h8c51;
    wire  [7:0] outs = {o_io_high_voltage_select, o_supply_level,
                        o_pin_gated, 1'b0};

    iosg_regs i_dut (
        .i_mclk                   (i_mclk),
        .i_rst                    (i_rst),
        .i_addr                   (i_addr),
        .i_wdata                  (i_wdata),
        .i_wr                     (i_wr),
        .i_rd                     (i_rd),
        .o_rdata                  (o_rdata),
        .i_io_supply_rail_3v3     (i_io_supply_rail_3v3),
        .i_pin                    (i_pin),
        .o_pin_gated              (o_pin_gated),
        .o_io_high_voltage_select (o_io_high_voltage_select),
        .o_supply_level           (o_supply_level)
    );
    initial begin
        forever #12.5 i_mclk = ~i_mclk;
    end
    initial begin
        #500000;
        errors++;
        conclude();
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] x);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= x;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, x);
    endtask
    task conclude;
        $display("Counts: %0d compared, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    function logic [7:0] exp_iov(input logic [7:0] x, input logic r);
        return x[6] ? x : {r, 1'b0, {2{r}}, x[3:0]};
    endfunction
    initial begin
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        repeat (10) @(posedge i_mclk);
        rd(OFS_IO_VOLTAGE_CONTROL, 8'h09);
        rd(OFS_PIN_LEVEL_READBACK, 8'h05);
        rd(OFS_PIN_INPUT_GATING, 8'h7f);
        $display("Test reset_defaults done");
        for (int i = 0; i < 24; i++) begin
            d = (i < 4) ? CORNER[i] : 8'($random(seed));
            g = 8'($random(seed));
            e = 8'($random(seed));
            ua = 8'h0c + 8'(4 * (i % 4));
            wr(OFS_IO_VOLTAGE_CONTROL, d);
            wr(OFS_PIN_LEVEL_READBACK, e);
            wr(OFS_PIN_INPUT_GATING, g);
            wr(ua, 8'hff);
            i_io_supply_rail_3v3 <= (i < 4) ? ~d[7] : 1'($random(seed));
            i_pin <= 4'($random(seed));
            repeat (10) @(posedge i_mclk);
            #1;
            v = exp_iov(d, i_io_supply_rail_3v3);
            chk(outs, {v[7], v[5:4], i_pin & g[3:0], 1'b0});
            rd(OFS_IO_VOLTAGE_CONTROL, v);
            rd(OFS_PIN_LEVEL_READBACK, {e[7:4], i_pin});
            rd(ua, 8'h00);
            wr(OFS_PIN_INPUT_GATING, ~g);
            rd(OFS_PIN_INPUT_GATING, ~g);
            $display("Test iteration %0d done", i);
        end
        @(posedge i_mclk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        repeat (10) @(posedge i_mclk);
        rd(OFS_IO_VOLTAGE_CONTROL, exp_iov(8'h09, i_io_supply_rail_3v3));
        rd(OFS_PIN_INPUT_GATING, 8'h7f);
        $display("Test mid_run_reset done");
        conclude();
    end
endmodule
